// [bench/reg_master.sv]
// Register-pointer master standing in for the serial slave engine outside the block.
// Assumes the block samples one-cycle strobes on the rising edge of clk.
`timescale 1ns/1ps
module reg_master (
   input wire logic clk,                 // System clock
   output rtc_trim_pkg::reg_req_s req_q  // Strobes towards the block
);
   initial req_q = '0;

   // One strobe for exactly one edge; data is then scrambled, not left valid
   task automatic pulse(input rtc_trim_pkg::reg_req_s r);
      @(posedge clk);
      req_q <= r;
      @(posedge clk);
      req_q <= {3'b000, ~r.data};
   endtask

   task automatic load(input logic [7:0] addr);
      pulse({3'b100, addr});
   endtask

   task automatic write(input logic [7:0] d);
      pulse({3'b010, d});
   endtask

   task automatic ack();
      pulse({3'b001, 8'h00});
   endtask
endmodule

// [bench/rtc_control_trim_charger_flag_test.sv]
// Self-checking bench for the control, trim, charger and halt-flag registers.
// Assumes reg_master drives the strobes and the oscillator monitor input is ours.
`timescale 1ns/1ps
module rtc_control_trim_charger_flag_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic osc_ok_pin = 1'b1;
   rtc_trim_pkg::reg_req_s req;
   rtc_trim_pkg::charger_s charger_q;
   logic [7:0] rdata_q;
   logic [3:0] ptr_q;
   logic test_pin_q;
   logic osc_disable_q;
   logic sec_pulse_q;
   int n_mismatch = 0;
   int checks_done = 0;
   int n_sec = 0;
   int n1;
   int n2;

   always #12.5 clk = ~clk;

   // A second needs 32768 timebase ticks, far longer than this run
   always @(posedge clk) begin
      if (sec_pulse_q === 1'b1) n_sec <= n_sec + 1;
   end

   reg_master master (.clk(clk), .req_q(req));

   rtc_control_trim_charger_flag DUT (.clk(clk), .rst(rst), .req(req), .osc_ok_pin(osc_ok_pin),
      .rdata_q(rdata_q), .ptr_q(ptr_q), .test_pin_q(test_pin_q), .charger_q(charger_q),
      .osc_disable_q(osc_disable_q), .sec_pulse_q(sec_pulse_q));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      master.load(a);
      settle(2);
      d = rdata_q;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      master.load(a);
      master.write(d);
      settle(2);
   endtask

   task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check(what, 16'(d), 16'(exp));
   endtask

   // Expected switch controls worked out from key, diode and resistor fields
   function automatic logic [4:0] chg_exp(input logic [7:0] v);
      logic on;
      on = v[7:4] == 4'ha && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && v[1:0] != 2'h0;
      chg_exp = on ? {1'b1, v[3:2] == 2'h2, v[1:0] == 2'h1, v[1:0] == 2'h2, v[1:0] == 2'h3} : 5'h0;
   endfunction

   task automatic wait_toggle(output int n);
      logic p;
      p = test_pin_q;
      n = 0;
      while (test_pin_q === p && n < 60000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   task automatic t_reset();
      check("pin idle", 16'(test_pin_q), 16'h1);
      check("charger idle", 16'(charger_q), 16'h0);
      rd_check("control reset", 8'h07, 8'h80);
      rd_check("charger reset", 8'h08, 8'h00);
      rd_check("flag reset", 8'h09, 8'h80);
      rd_check("seconds reset", 8'h00, 8'h00);
   endtask

   task automatic t_pointer();
      master.load(8'h07);
      master.write(8'h80);
      settle(1);
      check("ptr after 07", 16'(ptr_q), 16'h0);
      master.load(8'h08);
      master.ack();
      settle(1);
      check("ptr after 08", 16'(ptr_q), 16'h9);
      master.ack();
      settle(1);
      check("ptr after 09", 16'(ptr_q), 16'h0);
      rd_check("unmapped", 8'h03, 8'h00);
   endtask

   task automatic t_static();
      wr_reg(8'h07, 8'h35);
      check("pin low", 16'(test_pin_q), 16'h0);
      rd_check("control 35", 8'h07, 8'h35);
      wr_reg(8'h07, 8'h9f);
      check("pin high", 16'(test_pin_q), 16'h1);
      rd_check("control 9f", 8'h07, 8'h9f);
   endtask

   task automatic t_charger();
      logic [7:0] vals [11] = '{8'ha5, 8'ha9, 8'ha6, 8'haa, 8'ha7, 8'hab, 8'ha1, 8'had,
                                8'ha4, 8'h55, 8'h00};
      foreach (vals[i]) begin
         wr_reg(8'h08, vals[i]);
         check("charger ctl", 16'(charger_q), 16'(chg_exp(vals[i])));
         rd_check("charger reg", 8'h08, vals[i]);
      end
   endtask

   // Half period of 512 Hz is 39062.5 system clocks; trim fields set must not move it
   task automatic t_freq();
      master.load(8'h07);
      master.write(8'he5);
      // Let the pin settle low; the tick phase survives the chain reset, so 31 to 32 ticks
      settle(3);
      wait_toggle(n1);
      wait_toggle(n2);
      check("first toggle", 16'(n1 >= 37800 && n1 <= 39100), 16'h1);
      check("half period", 16'(n2 >= 39060 && n2 <= 39065), 16'h1);
      check("no early second", 16'(n_sec), 16'h0);
      wr_reg(8'h07, 8'h80);
   endtask

   task automatic t_flags();
      wr_reg(8'h09, 8'hff);
      rd_check("flag write 1", 8'h09, 8'h80);
      wr_reg(8'h09, 8'h00);
      rd_check("flag cleared", 8'h09, 8'h00);
      wr_reg(8'h00, 8'h80);
      check("osc disable", 16'(osc_disable_q), 16'h1);
      settle(8);
      rd_check("flag on disable", 8'h09, 8'h80);
      rd_check("seconds bit", 8'h00, 8'h80);
      wr_reg(8'h00, 8'h00);
      settle(8);
      wr_reg(8'h09, 8'h00);
      rd_check("flag stays clear", 8'h09, 8'h00);
      @(posedge clk);
      osc_ok_pin <= 1'b0;
      settle(8);
      rd_check("flag on osc loss", 8'h09, 8'h80);
      @(posedge clk);
      osc_ok_pin <= 1'b1;
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      #(25 * 95000);
      n_mismatch++;
      stop_test();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      settle(2);
      t_reset();
      t_pointer();
      t_static();
      t_charger();
      t_freq();
      t_flags();
      stop_test();
   end
endmodule

// [rtl/osc_tick_gen.sv]
// Fractional divider that turns the system clock into 32.768 kHz enable pulses.
// Assumes one clock; the pulse train stops while the timebase is not running.
`timescale 1ns/1ps
module osc_tick_gen #(
   parameter int CLK_HZ = rtc_trim_pkg::CLK_HZ,
   parameter int OSC_HZ = rtc_trim_pkg::OSC_HZ
) (
   input wire logic clk,    // System clock
   input wire logic rst,    // Asynchronous reset, active high
   input wire logic run,    // Timebase running
   output logic tick_q      // One-cycle timebase pulse
);
   localparam int AW = $clog2(CLK_HZ) + 1;
   localparam logic [AW-1:0] STEP = AW'(OSC_HZ);
   localparam logic [AW-1:0] WRAP = AW'(CLK_HZ - OSC_HZ);

   logic [AW-1:0] acc_q;

   // Accumulating keeps the long-run rate exact without a PLL
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q <= '0;
         tick_q <= 1'b0;
      end else if (!run) begin
         tick_q <= 1'b0;
      end else if (acc_q >= WRAP) begin
         acc_q <= acc_q - WRAP;
         tick_q <= 1'b1;
      end else begin
         acc_q <= acc_q + STEP;
         tick_q <= 1'b0;
      end
   end
endmodule

// [rtl/rtc_control_trim_charger_flag.sv]
// Control, trim, charger-select and halt-flag registers of a serial clock, with trim engine.
// Assumes the serial slave engine outside delivers pointer loads, byte writes and read acks
// as one-cycle strobes on clk; osc_ok_pin comes from the analog oscillator monitor.
// What this block does
// R01 - With frequency test off, test pin follows the static level bit.
// R02 - Static level bit powers up as 1, so test pin idles high.
// R03 - With frequency test on, test pin toggles at 512 Hz; select resets to 0.
// R04 - Control bit 5 is trim sign: 1 speeds up, 0 slows down; resets 0.
// R05 - Control bits 4..0 hold trim magnitude 0..31; reset 0.
// R06 - Charger enabled only when key field equals 1010.
// R07 - Charger register clears to zero at power-up, charger off.
// R08 - Diode field 01 no diode, 10 one diode, 00 and 11 disable.
// R09 - Resistor field 01 small, 10 2k, 11 4k, 00 disables.
// R10 - Halt flag bit 7 sets when timebase stops, including power-up.
// R11 - Oscillator disable set to 1 stops timebase and raises halt flag.
// R12 - Halt flag stays 1 until written 0; writing 1 leaves it.
// R13 - Flag bits 6..0 read 0 and ignore writes.
// R14 - Trim adds or removes counts at the divide-by-256 stage.
// R15 - Trim cycle is 64 minutes; first 62 may each get one corrected second.
// R16 - Corrected second blanks 128 or inserts 256 timebase cycles.
// R17 - First 2 times magnitude minutes of each cycle are corrected.
// R18 - 512 Hz test output is tapped ahead of the trim stage.
// R19 - Any control register write resets the divider chain.
// R20 - Seconds bit 7 is oscillator disable: 1 stops, 0 runs.
// R21 - Pointer reaches 08h only by loading, 09h by loading or stepping from 08h; wraps to 00h after 07h or 09h.
// R22 - Trim applies at a fixed second, on timebase ticks, only while running.
// R23 - Any non-enabling charger combination turns off all charger switches.
`timescale 1ns/1ps
module rtc_control_trim_charger_flag (
   input wire logic clk,                         // 40 MHz system clock
   input wire logic rst,                         // Asynchronous reset, active high
   input wire rtc_trim_pkg::reg_req_s req,       // Pointer load, write and read-ack strobes
   input wire logic osc_ok_pin,                  // Oscillator amplitude good, asynchronous
   output logic [7:0] rdata_q,                   // Byte at the current pointer
   output logic [3:0] ptr_q,                     // Register pointer
   output logic test_pin_q,                      // Test pin level
   output rtc_trim_pkg::charger_s charger_q,     // Charger switch controls
   output logic osc_disable_q,                   // Oscillator disable bit
   output logic sec_pulse_q                      // One pulse per trimmed second
);
   logic [7:0] control_q;
   logic [7:0] charger_sel_q;
   logic osc_halt_flag_q;
   logic osc_ok_s1_q;
   logic osc_ok_s2_q;
   logic run_q;
   logic running;
   logic tick;
   logic sq512;
   logic div_sec;
   logic div_clr_q;
   logic halt_event;
   logic wr_ctrl;
   logic wr_chg;
   logic wr_flag;
   logic wr_secs;
   logic step_ptr;
   logic [3:0] charger_key;
   logic [1:0] diode_sel;
   logic [1:0] resistor_choice;
   logic charger_on;
   logic [7:0] rd_mux;

   assign wr_ctrl = req.wr && ptr_q == rtc_trim_pkg::ADDR_CONTROL;
   assign wr_chg = req.wr && ptr_q == rtc_trim_pkg::ADDR_CHARGER;
   assign wr_flag = req.wr && ptr_q == rtc_trim_pkg::ADDR_FLAGS;
   assign wr_secs = req.wr && ptr_q == rtc_trim_pkg::ADDR_SECONDS;
   assign step_ptr = req.wr || req.rd_done;

   // Pin input passes two flops before anything reads it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_ok_s1_q <= 1'b0;
         osc_ok_s2_q <= 1'b0;
      end else begin
         osc_ok_s1_q <= osc_ok_pin;
         osc_ok_s2_q <= osc_ok_s1_q;
      end
   end

   assign running = osc_ok_s2_q && !osc_disable_q; // [R11] [R20]
   assign halt_event = run_q && !running; // [R10] [R11]

   // Pointer: loads land anywhere, increments wrap after the clock block or the flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_q <= rtc_trim_pkg::ADDR_SECONDS;
      end else if (req.ptr_load) begin
         ptr_q <= req.data[3:0];
      end else if (step_ptr) begin
         if (ptr_q == rtc_trim_pkg::ADDR_CONTROL || ptr_q >= rtc_trim_pkg::ADDR_FLAGS)
            ptr_q <= rtc_trim_pkg::ADDR_SECONDS; // [R21]
         else
            ptr_q <= ptr_q + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         control_q <= rtc_trim_pkg::CONTROL_RESET; // [R02] [R03] [R04] [R05]
      end else if (wr_ctrl) begin
         control_q <= req.data; // [R04] [R05]
      end
   end

   // A control write restarts the chain so trim changes start from a clean second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_clr_q <= 1'b0;
      end else begin
         div_clr_q <= wr_ctrl; // [R19]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         charger_sel_q <= rtc_trim_pkg::CHARGER_RESET; // [R07]
      end else if (wr_chg) begin
         charger_sel_q <= req.data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_disable_q <= rtc_trim_pkg::OSC_DISABLE_RESET;
      end else if (wr_secs) begin
         osc_disable_q <= req.data[rtc_trim_pkg::BIT_OSC_DISABLE]; // [R20]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_q <= 1'b0;
      end else begin
         run_q <= running;
      end
   end

   // Reset stands for first power, which counts as a stop; a stop beats a same-cycle clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_halt_flag_q <= rtc_trim_pkg::HALT_FLAG_RESET; // [R10]
      end else if (halt_event) begin
         osc_halt_flag_q <= 1'b1; // [R10] [R11]
      end else if (wr_flag && !req.data[rtc_trim_pkg::BIT_HALT_FLAG]) begin
         osc_halt_flag_q <= 1'b0; // [R12]
      end
   end

   assign charger_key = charger_sel_q[rtc_trim_pkg::KEY_MSB:rtc_trim_pkg::KEY_LSB];
   assign diode_sel = charger_sel_q[rtc_trim_pkg::DIODE_MSB:rtc_trim_pkg::DIODE_LSB];
   assign resistor_choice = charger_sel_q[rtc_trim_pkg::RES_MSB:rtc_trim_pkg::RES_LSB];
   assign charger_on = charger_key == rtc_trim_pkg::CHARGER_KEY_ON // [R06]
      && (diode_sel == rtc_trim_pkg::DIODE_NONE || diode_sel == rtc_trim_pkg::DIODE_ONE) // [R08]
      && resistor_choice != 2'h0; // [R09]

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         charger_q <= '0; // [R07]
      end else if (!charger_on) begin
         charger_q <= '0; // [R23]
      end else begin
         charger_q.enable <= 1'b1;
         charger_q.diode <= diode_sel == rtc_trim_pkg::DIODE_ONE; // [R08]
         charger_q.res_small <= resistor_choice == rtc_trim_pkg::RES_SMALL; // [R09]
         charger_q.res_2k <= resistor_choice == rtc_trim_pkg::RES_2K;
         charger_q.res_4k <= resistor_choice == rtc_trim_pkg::RES_4K;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         test_pin_q <= 1'b1; // [R02]
      end else if (control_q[rtc_trim_pkg::BIT_FREQ_TEST]) begin
         test_pin_q <= sq512; // [R03]
      end else begin
         test_pin_q <= control_q[rtc_trim_pkg::BIT_STATIC_LEVEL]; // [R01]
      end
   end

   // Time registers live elsewhere; only the disable bit of seconds is held here
   always_comb begin
      rd_mux = 8'h00;
      case (ptr_q)
         rtc_trim_pkg::ADDR_SECONDS: rd_mux[rtc_trim_pkg::BIT_OSC_DISABLE] = osc_disable_q;
         rtc_trim_pkg::ADDR_CONTROL: rd_mux = control_q;
         rtc_trim_pkg::ADDR_CHARGER: rd_mux = charger_sel_q;
         rtc_trim_pkg::ADDR_FLAGS: rd_mux[rtc_trim_pkg::BIT_HALT_FLAG] = osc_halt_flag_q; // [R13]
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
         sec_pulse_q <= 1'b0;
      end else begin
         rdata_q <= rd_mux;
         sec_pulse_q <= div_sec;
      end
   end

   osc_tick_gen #(
      .CLK_HZ(rtc_trim_pkg::CLK_HZ),
      .OSC_HZ(rtc_trim_pkg::OSC_HZ)
   ) u_tick (
      .clk(clk),
      .rst(rst),
      .run(running), // [R22]
      .tick_q(tick)
   );

   trim_divider u_div (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .clr(div_clr_q),
      .trim_sign(control_q[rtc_trim_pkg::BIT_TRIM_SIGN]),
      .trim_magnitude(control_q[rtc_trim_pkg::TRIM_MSB:0]),
      .sq512_q(sq512),
      .sec_pulse_q(div_sec)
   );

   a_static_level: assert property (@(posedge clk) disable iff (rst) // [R01]
      !control_q[rtc_trim_pkg::BIT_FREQ_TEST] ##1 !$past(rst)
      |-> test_pin_q == $past(control_q[rtc_trim_pkg::BIT_STATIC_LEVEL]))
      else $error("test pin does not follow static level");
   a_reset_idle: assert property (@(posedge clk) disable iff (rst) // [R02]
      $past(rst) |-> control_q == rtc_trim_pkg::CONTROL_RESET && test_pin_q)
      else $error("control not at reset value after reset");
   a_trim_store: assert property (@(posedge clk) disable iff (rst) // [R05]
      wr_ctrl |=> control_q == $past(req.data) && div_clr_q)
      else $error("control write not stored or chain not cleared");
   a_key_gate: assert property (@(posedge clk) disable iff (rst) // [R06]
      charger_q.enable |-> $past(charger_key) == rtc_trim_pkg::CHARGER_KEY_ON)
      else $error("charger on without key");
   a_diode_off: assert property (@(posedge clk) disable iff (rst) // [R08]
      (diode_sel == 2'h0 || diode_sel == 2'h3) |=> charger_q == '0)
      else $error("charger on with illegal diode field");
   a_res_off: assert property (@(posedge clk) disable iff (rst) // [R09]
      resistor_choice == 2'h0 |=> !charger_q.enable)
      else $error("charger on with no resistor");
   a_halt_set: assert property (@(posedge clk) disable iff (rst) // [R10]
      halt_event |=> osc_halt_flag_q)
      else $error("halt flag not set on stop");
   a_halt_hold: assert property (@(posedge clk) disable iff (rst) // [R12]
      osc_halt_flag_q && !(wr_flag && !req.data[rtc_trim_pkg::BIT_HALT_FLAG])
      |=> osc_halt_flag_q)
      else $error("halt flag dropped without a zero write");
   a_flag_low: assert property (@(posedge clk) disable iff (rst) // [R13]
      ptr_q == rtc_trim_pkg::ADDR_FLAGS && !req.ptr_load && !step_ptr
      |=> rdata_q[6:0] == 7'h00)
      else $error("flag low bits not zero");
   a_ptr_wrap: assert property (@(posedge clk) disable iff (rst) // [R21]
      step_ptr && !req.ptr_load && ptr_q == rtc_trim_pkg::ADDR_CONTROL
      |=> ptr_q == rtc_trim_pkg::ADDR_SECONDS)
      else $error("pointer did not wrap after control");

   a_freq_follow: assert property (@(posedge clk) disable iff (rst) // [R03]
      control_q[rtc_trim_pkg::BIT_FREQ_TEST] |=> test_pin_q == $past(sq512))
      else $error("test pin does not follow the 512 Hz tap");

   a_osc_store: assert property (@(posedge clk) disable iff (rst) // [R20]
      wr_secs |=> osc_disable_q == $past(req.data[rtc_trim_pkg::BIT_OSC_DISABLE]))
      else $error("oscillator disable bit not stored");

   a_halt_clear: assert property (@(posedge clk) disable iff (rst) // [R12]
      wr_flag && !req.data[rtc_trim_pkg::BIT_HALT_FLAG] && !halt_event |=> !osc_halt_flag_q)
      else $error("halt flag not cleared by a zero write");

   a_disable_halt: assert property (@(posedge clk) disable iff (rst) // [R11]
      wr_secs && req.data[rtc_trim_pkg::BIT_OSC_DISABLE] && running |-> ##2 osc_halt_flag_q)
      else $error("halt flag not raised by oscillator disable");

   a_diode_map: assert property (@(posedge clk) disable iff (rst) // [R08]
      charger_q.enable |-> charger_q.diode == ($past(diode_sel) == rtc_trim_pkg::DIODE_ONE))
      else $error("diode switch does not match diode field");

   a_res_onehot: assert property (@(posedge clk) disable iff (rst) // [R09]
      charger_q.enable |-> $onehot({charger_q.res_small, charger_q.res_2k, charger_q.res_4k}))
      else $error("not exactly one resistor selected");

   a_charger_zero: assert property (@(posedge clk) disable iff (rst) // [R23]
      !charger_q.enable |-> charger_q == '0)
      else $error("charger switch on while disabled");

   a_charger_store: assert property (@(posedge clk) disable iff (rst) // [R06]
      wr_chg |=> charger_sel_q == $past(req.data))
      else $error("charger select write not stored");

   a_ptr_load: assert property (@(posedge clk) disable iff (rst) // [R21]
      req.ptr_load |=> ptr_q == $past(req.data[3:0]))
      else $error("pointer load not taken");

   a_chain_clear: assert property (@(posedge clk) disable iff (rst) // [R19]
      div_clr_q |=> !sq512)
      else $error("divider chain not reset by control write");

   a_tick_gate: assert property (@(posedge clk) disable iff (rst) // [R22]
      !running |=> !tick)
      else $error("timebase ticks while stopped");
   c_freq_test: cover property (@(posedge clk) disable iff (rst)
      control_q[rtc_trim_pkg::BIT_FREQ_TEST] && $rose(test_pin_q));
   c_charger_on: cover property (@(posedge clk) disable iff (rst) charger_q.enable);
   c_halt_clear: cover property (@(posedge clk) disable iff (rst) $fell(osc_halt_flag_q));
endmodule

// [rtl/rtc_trim_pkg.sv]
// Constants and carrier types shared by the control, trim, charger and flag logic.
// Assumes a 40 MHz system clock and a 32.768 kHz timebase derived from it.
package rtc_trim_pkg;

   // Register pointer values
   localparam logic [3:0] ADDR_SECONDS = 4'h0;
   localparam logic [3:0] ADDR_CONTROL = 4'h7;
   localparam logic [3:0] ADDR_CHARGER = 4'h8;
   localparam logic [3:0] ADDR_FLAGS = 4'h9;

   // Field positions
   localparam int BIT_STATIC_LEVEL = 7;
   localparam int BIT_FREQ_TEST = 6;
   localparam int BIT_TRIM_SIGN = 5;
   localparam int TRIM_MSB = 4;
   localparam int BIT_OSC_DISABLE = 7;
   localparam int BIT_HALT_FLAG = 7;
   localparam int KEY_MSB = 7;
   localparam int KEY_LSB = 4;
   localparam int DIODE_MSB = 3;
   localparam int DIODE_LSB = 2;
   localparam int RES_MSB = 1;
   localparam int RES_LSB = 0;

   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h80;
   localparam logic [7:0] CHARGER_RESET = 8'h00;
   localparam logic OSC_DISABLE_RESET = 1'b0;
   localparam logic HALT_FLAG_RESET = 1'b1;

   // Charger decode patterns
   localparam logic [3:0] CHARGER_KEY_ON = 4'ha;
   localparam logic [1:0] DIODE_NONE = 2'h1;
   localparam logic [1:0] DIODE_ONE = 2'h2;
   localparam logic [1:0] RES_SMALL = 2'h1;
   localparam logic [1:0] RES_2K = 2'h2;
   localparam logic [1:0] RES_4K = 2'h3;

   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int OSC_HZ = 32_768;
   localparam int TEST_HZ = 512;
   localparam int TEST_HALF_TICKS = OSC_HZ / (2 * TEST_HZ);
   localparam int CAL_STAGE = 256;
   localparam int STEPS_PER_SEC = OSC_HZ / CAL_STAGE;
   localparam int BLANK_TICKS = 128;
   localparam int INSERT_TICKS = 256;
   localparam int INSERT_STEPS = INSERT_TICKS / CAL_STAGE + 1;
   localparam int SEC_PER_MIN = 60;
   localparam int CYCLE_MIN = 64;
   localparam int CORRECTED_MIN_MAX = 62;
   localparam int CAL_SECOND = 0;
   localparam int CAL_STEP_POS = 0;

   typedef struct packed {
      logic enable;
      logic diode;
      logic res_small;
      logic res_2k;
      logic res_4k;
   } charger_s;

   typedef struct packed {
      logic ptr_load;
      logic wr;
      logic rd_done;
      logic [7:0] data;
   } reg_req_s;

endpackage

// [rtl/trim_divider.sv]
// Timebase divider chain with digital trim at the divide-by-256 stage and a 512 Hz tap.
// Assumes tick is a one-cycle enable at the timebase rate and clr a one-cycle pulse.
`timescale 1ns/1ps
module trim_divider (
   input wire logic clk,              // System clock
   input wire logic rst,              // Asynchronous reset, active high
   input wire logic tick,             // Timebase pulse
   input wire logic clr,              // Divider chain reset pulse
   input wire logic trim_sign,        // 1 speeds up, 0 slows down
   input wire logic [4:0] trim_magnitude, // Corrected minutes / 2
   output logic sq512_q,              // 512 Hz square wave
   output logic sec_pulse_q           // One pulse per second
);
   localparam int PW = $clog2(rtc_trim_pkg::TEST_HALF_TICKS);
   localparam int HW = $clog2(rtc_trim_pkg::STEPS_PER_SEC);
   localparam logic [PW-1:0] PRE_LAST = PW'(rtc_trim_pkg::TEST_HALF_TICKS - 1);
   localparam logic [HW-1:0] HI_LAST = HW'(rtc_trim_pkg::STEPS_PER_SEC - 1);
   localparam logic [HW-1:0] HI_CAL = HW'(rtc_trim_pkg::CAL_STEP_POS);
   localparam logic [HW-1:0] HI_INS = HW'(rtc_trim_pkg::INSERT_STEPS);
   localparam logic [5:0] SEC_LAST = 6'(rtc_trim_pkg::SEC_PER_MIN - 1);
   localparam logic [5:0] SEC_CAL = 6'(rtc_trim_pkg::CAL_SECOND);
   localparam logic [5:0] MIN_LAST = 6'(rtc_trim_pkg::CYCLE_MIN - 1);
   localparam logic [5:0] MIN_MAX = 6'(rtc_trim_pkg::CORRECTED_MIN_MAX);
   localparam logic [7:0] BLANK_N = 8'(rtc_trim_pkg::BLANK_TICKS);

   logic [PW-1:0] pre_q;
   logic [7:0] lo_q;
   logic [HW-1:0] hi_q;
   logic [5:0] sec_q;
   logic [5:0] min_q;
   logic [7:0] blank_q;
   logic corrected;
   logic carry;

   assign corrected = (min_q < {trim_magnitude, 1'b0}) && (min_q < MIN_MAX)
      && (sec_q == SEC_CAL); // [R15] [R17]
   assign carry = tick && (blank_q == 8'h00) && (lo_q == 8'hff);

   // Tap ahead of the trim stage so trimming never moves the test frequency
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_q <= '0;
         sq512_q <= 1'b0;
      end else if (clr) begin
         pre_q <= '0; // [R19]
         sq512_q <= 1'b0;
      end else if (tick) begin
         pre_q <= (pre_q == PRE_LAST) ? '0 : pre_q + 1'b1;
         if (pre_q == PRE_LAST) sq512_q <= ~sq512_q; // [R03] [R18]
      end
   end

   // Divide-by-256 stage; blanking freezes it for the slow-down case
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lo_q <= 8'h00;
         blank_q <= 8'h00;
      end else if (clr) begin
         lo_q <= 8'h00;
         blank_q <= 8'h00;
      end else if (tick) begin
         if (blank_q != 8'h00) begin
            blank_q <= blank_q - 8'h01; // [R16]
         end else begin
            lo_q <= lo_q + 8'h01;
            if (lo_q == 8'hff && hi_q == HI_CAL && corrected && !trim_sign)
               blank_q <= BLANK_N; // [R14] [R16] [R22]
         end
      end
   end

   // Upper stage; the speed-up case skips 256 timebase cycles at one step
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hi_q <= '0;
         sec_q <= 6'h00;
         min_q <= 6'h00;
         sec_pulse_q <= 1'b0;
      end else if (clr) begin
         hi_q <= '0; // [R19]
         sec_pulse_q <= 1'b0;
      end else begin
         sec_pulse_q <= carry && (hi_q == HI_LAST);
         if (carry) begin
            if (hi_q == HI_CAL && corrected && trim_sign) begin
               hi_q <= HI_INS; // [R14] [R16] [R22]
            end else if (hi_q == HI_LAST) begin
               hi_q <= '0;
               sec_q <= (sec_q == SEC_LAST) ? 6'h00 : sec_q + 6'h01;
               if (sec_q == SEC_LAST) min_q <= (min_q == MIN_LAST) ? 6'h00 : min_q + 6'h01;
            end else begin
               hi_q <= hi_q + 1'b1;
            end
         end
      end
   end

   a_blank_len: assert property (@(posedge clk) disable iff (rst) // [R16]
      $rose(blank_q != 8'h00) |-> blank_q == BLANK_N)
      else $error("blank window did not start at full length");
   a_trim_window: assert property (@(posedge clk) disable iff (rst) // [R17]
      $rose(blank_q == BLANK_N) |-> ($past(min_q) < {$past(trim_magnitude), 1'b0}))
      else $error("correction outside selected minutes");
   c_blank: cover property (@(posedge clk) disable iff (rst) blank_q == BLANK_N);
   c_insert: cover property (@(posedge clk) disable iff (rst)
      carry && hi_q == HI_CAL && corrected && trim_sign);
endmodule
